// >>> hdl/ccpcu_regs.svh
`ifndef CCPCU_REGS_SVH
`define CCPCU_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CCPCU_OFS_CTRL 8'h00
`define CCPCU_OFS_VALUE 8'h04
`define CCPCU_OFS_COUNT 8'h08
`define CCPCU_OFS_CFG 8'h0C
`define CCPCU_OFS_LIMIT 8'h10
`define CCPCU_OFS_PCTL 8'h14
`define CCPCU_OFS_STATUS 8'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCPCU_CTRL_EN 7
`define CCPCU_CTRL_OUT 5
`define CCPCU_CTRL_FMT 4
`define CCPCU_CFG_EXT 0
`define CCPCU_CFG_ADC 1
`define CCPCU_CFG_IE 2
`define CCPCU_PCTL_ON 2
`define CCPCU_ST_CIF 0
`define CCPCU_ST_PIF 1
`define CCPCU_ST_BASE_LSB 16
`define CCPCU_DUTY_LEFT_LSB 6
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define CCPCU_CTRL_RST 6'h00
`define CCPCU_LIMIT_RST 8'hFF
`define CCPCU_PHASE_LAST 2'h3
`define CCPCU_PRE_MAX_1 6'h00
`define CCPCU_PRE_MAX_4 6'h03
`define CCPCU_PRE_MAX_16 6'h0F
`define CCPCU_PRE_MAX_64 6'h3F
`endif

// >>> hdl/ccpcu_pkg.sv
package ccpcu_pkg;
	// ----------------------------------------
	// Channel mode codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		CCPCU_OFF = 4'h0,
		CCPCU_CMP_TOG_CLR = 4'h1,
		CCPCU_CMP_TOG = 4'h2,
		CCPCU_CMP_SET = 4'h8,
		CCPCU_CMP_CLR = 4'h9,
		CCPCU_CMP_PULSE = 4'hA,
		CCPCU_CMP_PULSE_CLR = 4'hB
	} ccpcu_mode_e;
	// Period timer prescale select
	typedef enum logic [1:0] {
		CCPCU_PS_1 = 2'h0,
		CCPCU_PS_4 = 2'h1,
		CCPCU_PS_16 = 2'h2,
		CCPCU_PS_64 = 2'h3
	} ccpcu_ps_e;
	// Channel control fields
	typedef struct packed {
		logic en;
		logic fmt;
		logic [3:0] mode;
	} ccpcu_ctrl_s;
	// Compare timebase configuration
	typedef struct packed {
		logic ie;
		logic adc;
		logic ext;
	} ccpcu_cfg_s;
	// Period timer control
	typedef struct packed {
		logic on;
		ccpcu_ps_e ps;
	} ccpcu_pctl_s;
endpackage

// >>> hdl/ccpcu_period_timer.sv
`timescale 1ns/1ps
`include "ccpcu_regs.svh"
module ccpcu_period_timer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Timing inputs
	input wire logic inst_tick,
	input wire logic run,
	input wire logic [1:0] phase,
	input wire ccpcu_pkg::ccpcu_ps_e ps,
	input wire logic [7:0] limit,
	// Time base outputs
	output logic [9:0] base10,
	output logic wrap
);
	// ----------------------------------------
	// Prescaler and 8-bit period count
	// ----------------------------------------
	logic [5:0] pre_q;
	logic [5:0] pre_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [5:0] pre_max;
	logic inc;
	logic [1:0] low2;

	// No postscaler exists here, so wrap is set purely by the period
	always_comb begin
		unique case (ps)
			ccpcu_pkg::CCPCU_PS_1: pre_max = `CCPCU_PRE_MAX_1;
			ccpcu_pkg::CCPCU_PS_4: pre_max = `CCPCU_PRE_MAX_4;
			ccpcu_pkg::CCPCU_PS_16: pre_max = `CCPCU_PRE_MAX_16;
			ccpcu_pkg::CCPCU_PS_64: pre_max = `CCPCU_PRE_MAX_64;
		endcase
		inc = ce & run & inst_tick & (pre_q >= pre_max);
		wrap = inc & (cnt_q == limit);
		pre_d = pre_q;
		if (ce & run & inst_tick) begin
			pre_d = (pre_q >= pre_max) ? 6'h00 : pre_q + 6'h01;
		end
		cnt_d = cnt_q;
		if (inc) begin
			cnt_d = wrap ? 8'h00 : cnt_q + 8'h01;
		end
	end

	// Low bits: clock phase at 1:1, else top prescaler bits
	// Time base as it stands after this edge, so a registered duty match
	// drops the pin exactly duty time base steps after the set, not one clock late
	always_comb begin
		unique case (ps)
			ccpcu_pkg::CCPCU_PS_1: low2 = phase + 2'h1;
			ccpcu_pkg::CCPCU_PS_4: low2 = pre_d[1:0];
			ccpcu_pkg::CCPCU_PS_16: low2 = pre_d[3:2];
			ccpcu_pkg::CCPCU_PS_64: low2 = pre_d[5:4];
		endcase
		base10 = {cnt_d, low2};
	end

	// Registers freeze while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 6'h00;
			cnt_q <= 8'h00;
		end else if (ce) begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

// >>> hdl/ccpcu_channel.sv
`timescale 1ns/1ps
`include "ccpcu_regs.svh"
// Function
// - Instruction-clocked timebase holds its count in sleep and resumes after.
// - Externally clocked timebase keeps counting through sleep.
// - Compare value is checked for equality against the 16-bit timebase count.
// - Match toggles, sets, clears or pulses output per mode, optionally clearing timer.
// - Mode codes: 11xx PWM, 1011/1010 pulse, 1001 low, 1000 high.
// - Every match sets the interrupt flag and, if selected, fires ADC trigger.
// - Timer resets on match only in modes 0001 and 1011.
// - Writing zero to control forces the compare output latch low.
// - Changing compare value between trigger and reset edge cancels the reset.
// - Compare in sleep needs a running timer; enabled flag raises wake.
// - PWM drives the pin with ten bits; period from 8-bit period limit.
// - PWM period is (limit + 1) times four clocks times prescale.
// - After count equals limit: clear, set pin unless 0%, load duty buffer.
// - No postscaler affects PWM period.
// - Duty may be written anytime; buffer loads only at period match.
// - Alignment bit picks left or right duty layout; ignored outside PWM.
// - Pulse width is duty times clock times prescale.
// - Time base is timer plus two low bits from phase or prescaler.
// - Time base equal to buffered duty drives pin low for the period.
module ccpcu_channel (
	// Clock, reset, freeze
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Asynchronous pins
	input wire logic ext_clk_pin,
	input wire logic sleep_req,
	// Channel outputs
	output logic channel_output_pin,
	output logic adc_trigger,
	output logic channel_interrupt_flag,
	output logic period_timer_flag,
	output logic wake_req
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == `CCPCU_OFS_CTRL) || (a == `CCPCU_OFS_VALUE) ||
			(a == `CCPCU_OFS_COUNT) || (a == `CCPCU_OFS_CFG) ||
			(a == `CCPCU_OFS_LIMIT) || (a == `CCPCU_OFS_PCTL) ||
			(a == `CCPCU_OFS_STATUS);
	endfunction

	function automatic logic is_cmp(input logic [3:0] m);
		is_cmp = (m == ccpcu_pkg::CCPCU_CMP_TOG_CLR) || (m == ccpcu_pkg::CCPCU_CMP_TOG) ||
			(m == ccpcu_pkg::CCPCU_CMP_SET) || (m == ccpcu_pkg::CCPCU_CMP_CLR) ||
			(m == ccpcu_pkg::CCPCU_CMP_PULSE) || (m == ccpcu_pkg::CCPCU_CMP_PULSE_CLR);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	ccpcu_pkg::ccpcu_ctrl_s ctrl_q, ctrl_d;
	ccpcu_pkg::ccpcu_cfg_s cfg_q, cfg_d;
	ccpcu_pkg::ccpcu_pctl_s pctl_q, pctl_d;
	logic [15:0] value_q, value_d;
	logic [15:0] count_q, count_d;
	logic [15:0] clr_val_q, clr_val_d;
	logic [7:0] limit_q, limit_d;
	logic [9:0] duty_buf_q, duty_buf_d;
	logic [1:0] phase_q, phase_d;
	logic cif_q, cif_d, pif_q, pif_d;
	logic out_q, out_d, pulse_q, pulse_d;
	logic armed_q, armed_d, clr_pend_q, clr_pend_d;
	logic adc_q, adc_d, wake_q, wake_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic ext_s1_q, ext_s2_q, ext_s3_q, sleep_s1_q, sleep_s2_q;
	logic inst_tick, ext_rise, tb_tick, cmp_hit, pwm_act, wr_en, wrap;
	logic [9:0] duty_sel, base10;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			sleep_s1_q <= 1'b0;
			sleep_s2_q <= 1'b0;
		end else if (ce) begin
			ext_s1_q <= ext_clk_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			sleep_s1_q <= sleep_req;
			sleep_s2_q <= sleep_s1_q;
		end
	end

	// ----------------------------------------
	// Event terms
	// ----------------------------------------
	// Instruction clock stops in sleep; the external edge does not
	assign inst_tick = ce & (phase_q == `CCPCU_PHASE_LAST) & ~sleep_s2_q;
	assign ext_rise = ce & ext_s2_q & ~ext_s3_q;
	assign tb_tick = cfg_q.ext ? ext_rise : inst_tick;
	// Armed only in the cycle after a count change, so one hit per value
	assign cmp_hit = ce & armed_q & ctrl_q.en & is_cmp(ctrl_q.mode) &
		(count_q == value_q);
	assign pwm_act = ctrl_q.en & (ctrl_q.mode[3:2] == 2'b11);
	// Alignment only matters to the PWM duty path
	assign duty_sel = ctrl_q.fmt ? value_q[15:`CCPCU_DUTY_LEFT_LSB] : value_q[9:0];
	assign wr_en = ce & psel & penable & pready_q & pwrite & addr_hit(paddr);

	// Period timer and 10-bit time base
	ccpcu_period_timer u_period (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.inst_tick(inst_tick),
		.run(pctl_q.on),
		.phase(phase_q),
		.ps(pctl_q.ps),
		.limit(limit_q),
		.base10(base10),
		.wrap(wrap)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		cfg_d = cfg_q;
		pctl_d = pctl_q;
		value_d = value_q;
		count_d = count_q;
		clr_val_d = clr_val_q;
		limit_d = limit_q;
		duty_buf_d = duty_buf_q;
		phase_d = phase_q + 2'h1;
		out_d = out_q;
		pulse_d = pulse_q;
		armed_d = 1'b0;
		clr_pend_d = clr_pend_q;
		adc_d = 1'b0;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		// Timebase increment, with pending clear checked against the value
		if (tb_tick) begin
			count_d = count_q + 16'h0001;
			armed_d = 1'b1;
			if (clr_pend_q) begin
				clr_pend_d = 1'b0;
				if (value_q == clr_val_q) begin
					count_d = 16'h0000;
				end
			end
			// A pulse lasts one timebase count
			if (pulse_q) begin
				out_d = 1'b0;
				pulse_d = 1'b0;
			end
		end
		// Compare actions
		if (cmp_hit) begin
			adc_d = cfg_q.adc;
			case (ctrl_q.mode)
				ccpcu_pkg::CCPCU_CMP_TOG_CLR, ccpcu_pkg::CCPCU_CMP_TOG: out_d = ~out_q;
				ccpcu_pkg::CCPCU_CMP_SET: out_d = 1'b1;
				ccpcu_pkg::CCPCU_CMP_CLR: out_d = 1'b0;
				default: begin
					out_d = 1'b1;
					pulse_d = 1'b1;
				end
			endcase
			// Remember the value so a later rewrite cancels the reset
			if (ctrl_q.mode == ccpcu_pkg::CCPCU_CMP_TOG_CLR ||
				ctrl_q.mode == ccpcu_pkg::CCPCU_CMP_PULSE_CLR) begin
				clr_pend_d = 1'b1;
				clr_val_d = value_q;
			end
		end
		// PWM: set and reload at period wrap, drop at duty match
		if (pwm_act) begin
			if (wrap) begin
				duty_buf_d = duty_sel;
				out_d = (duty_sel != 10'h000);
			end else if (base10 == duty_buf_q) begin
				out_d = 1'b0;
			end
		end
		// APB access phase: answer one cycle after penable rises
		if (ce & psel & penable & ~pready_q) begin
			pready_d = 1'b1;
			pslverr_d = ~addr_hit(paddr);
			if (!pwrite) begin
				case (paddr)
					`CCPCU_OFS_CTRL: prdata_d = {24'h000000, ctrl_q.en, 1'b0, out_q,
						ctrl_q.fmt, ctrl_q.mode};
					`CCPCU_OFS_VALUE: prdata_d = {16'h0000, value_q};
					`CCPCU_OFS_COUNT: prdata_d = {16'h0000, count_q};
					`CCPCU_OFS_CFG: prdata_d = {29'h00000000, cfg_q};
					`CCPCU_OFS_LIMIT: prdata_d = {24'h000000, limit_q};
					`CCPCU_OFS_PCTL: prdata_d = {29'h00000000, pctl_q};
					`CCPCU_OFS_STATUS: prdata_d = {6'h00, base10, 14'h0000, pif_q, cif_q};
					default: prdata_d = 32'h00000000;
				endcase
			end
		end
		// Register writes take effect at the completing edge
		if (wr_en) begin
			case (paddr)
				`CCPCU_OFS_CTRL: begin
					ctrl_d = {pwdata[`CCPCU_CTRL_EN], pwdata[`CCPCU_CTRL_FMT], pwdata[3:0]};
					if (pwdata[7:0] == 8'h00) begin
						out_d = 1'b0;
						pulse_d = 1'b0;
						clr_pend_d = 1'b0;
					end
				end
				`CCPCU_OFS_VALUE: value_d = pwdata[15:0];
				`CCPCU_OFS_COUNT: begin
					count_d = pwdata[15:0];
					armed_d = 1'b1;
				end
				`CCPCU_OFS_CFG: cfg_d = pwdata[2:0];
				`CCPCU_OFS_LIMIT: limit_d = pwdata[7:0];
				`CCPCU_OFS_PCTL: pctl_d = pwdata[2:0];
				default: ;
			endcase
		end
		// Sticky flags: hardware set beats a same-cycle clear
		cif_d = (cif_q & ~(wr_en & (paddr == `CCPCU_OFS_STATUS) & pwdata[`CCPCU_ST_CIF])) |
			cmp_hit;
		pif_d = (pif_q & ~(wr_en & (paddr == `CCPCU_OFS_STATUS) & pwdata[`CCPCU_ST_PIF])) |
			wrap;
		wake_d = cif_d & cfg_d.ie;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CCPCU_CTRL_RST;
			cfg_q <= 3'h0;
			pctl_q <= 3'h0;
			value_q <= 16'h0000;
			count_q <= 16'h0000;
			clr_val_q <= 16'h0000;
			limit_q <= `CCPCU_LIMIT_RST;
			duty_buf_q <= 10'h000;
			phase_q <= 2'h0;
			cif_q <= 1'b0;
			pif_q <= 1'b0;
			out_q <= 1'b0;
			pulse_q <= 1'b0;
			armed_q <= 1'b0;
			clr_pend_q <= 1'b0;
			adc_q <= 1'b0;
			wake_q <= 1'b0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else if (ce) begin
			ctrl_q <= ctrl_d;
			cfg_q <= cfg_d;
			pctl_q <= pctl_d;
			value_q <= value_d;
			count_q <= count_d;
			clr_val_q <= clr_val_d;
			limit_q <= limit_d;
			duty_buf_q <= duty_buf_d;
			phase_q <= phase_d;
			cif_q <= cif_d;
			pif_q <= pif_d;
			out_q <= out_d;
			pulse_q <= pulse_d;
			armed_q <= armed_d;
			clr_pend_q <= clr_pend_d;
			adc_q <= adc_d;
			wake_q <= wake_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign channel_output_pin = out_q;
	assign adc_trigger = adc_q;
	assign channel_interrupt_flag = cif_q;
	assign period_timer_flag = pif_q;
	assign wake_req = wake_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_FLAG_ON_MATCH: assert property (cmp_hit |=> cif_q)
		else $error("flag not set after compare match");
	AST_ADC_TRIG: assert property (cmp_hit && cfg_q.adc |=> adc_trigger ##1 !adc_trigger)
		else $error("adc trigger not a single pulse after match");
	AST_SET_OUT: assert property (cmp_hit && ctrl_q.mode == 4'h8 |=> channel_output_pin)
		else $error("set mode did not drive output high");
	AST_CLR_OUT: assert property (cmp_hit && ctrl_q.mode == 4'h9 |=> !channel_output_pin)
		else $error("clear mode did not drive output low");
	AST_TOGGLE: assert property (cmp_hit && ctrl_q.mode == 4'h2 && !wr_en
		|=> channel_output_pin != $past(channel_output_pin))
		else $error("toggle mode did not invert output");
	AST_TIMER_CLEAR: assert property (tb_tick && clr_pend_q && value_q == clr_val_q && !wr_en
		|=> count_q == 16'h0000)
		else $error("timer not reset after clearing match");
	AST_NO_CLEAR_CHANGED: assert property (tb_tick && clr_pend_q && value_q != clr_val_q &&
		!wr_en |=> count_q == $past(count_q) + 16'h0001)
		else $error("timer reset despite changed compare value");
	AST_CTRL_ZERO: assert property (wr_en && paddr == 8'h00 && pwdata[7:0] == 8'h00
		|=> !channel_output_pin)
		else $error("zero control write left output latch high");
	AST_SLEEP_HOLD: assert property (ce && sleep_s2_q && !cfg_q.ext && !wr_en
		|=> $stable(count_q))
		else $error("instruction-clocked timebase moved in sleep");
	AST_PWM_BUF: assert property (ce && pwm_act && wrap |=> duty_buf_q == $past(duty_sel))
		else $error("duty buffer not loaded at period wrap");
	AST_PWM_LOW: assert property (ce && pwm_act && !wrap && !wr_en && base10 == duty_buf_q
		|=> !channel_output_pin)
		else $error("pwm output not cleared at duty match");
	AST_ONCE: assert property (cmp_hit |=> !cmp_hit)
		else $error("compare acted twice on one count");

	COV_PULSE: cover property (cmp_hit && ctrl_q.mode == 4'hA ##[1:8] !channel_output_pin);
	COV_CLEAR: cover property (cmp_hit && ctrl_q.mode == 4'hB ##[1:300] count_q == 16'h0000);
	COV_PWM_WRAP: cover property (pwm_act && wrap ##[1:1000] !channel_output_pin);
endmodule

// >>> test/ccpcu_load_model.sv
`timescale 1ns/1ps
module ccpcu_load_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin routed to the load as an output of the channel
	input wire logic pin,
	// Measurements in pclk cycles
	output logic [31:0] last_period,
	output logic [31:0] last_high,
	output logic [31:0] rises
);
	logic [31:0] cyc;
	logic [31:0] rise_t;
	logic prev;
	// ----------------------------------------
	// Edge time stamps
	// ----------------------------------------
	// Load only listens, so nothing is driven back onto the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc <= 32'h0;
			rise_t <= 32'h0;
			prev <= 1'b0;
			last_period <= 32'h0;
			last_high <= 32'h0;
			rises <= 32'h0;
		end else begin
			cyc <= cyc + 32'h1;
			prev <= pin;
			if (pin && !prev) begin
				last_period <= cyc - rise_t;
				rise_t <= cyc;
				rises <= rises + 32'h1;
			end
			if (!pin && prev) begin
				last_high <= cyc - rise_t;
			end
		end
	end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
`include "ccpcu_regs.svh"
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic ext_clk_pin = 1'b0;
	logic sleep_req = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, pin, adc_trigger, cflag, pflag, wake_req;
	logic [31:0] last_period, last_high, rises, rd, c0;
	logic err;
	int miscompares = 0;
	int num_checks = 0;
	int adc_cnt = 0;

	ccpcu_channel dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
		.sleep_req(sleep_req), .channel_output_pin(pin), .adc_trigger(adc_trigger),
		.channel_interrupt_flag(cflag), .period_timer_flag(pflag), .wake_req(wake_req));
	ccpcu_load_model load (.pclk(pclk), .presetn(presetn), .pin(pin),
		.last_period(last_period), .last_high(last_high), .rises(rises));

	// 250 MHz clock
	initial forever #2 pclk = ~pclk;
	// Count trigger pulses, each one cycle long
	always @(posedge pclk) if (adc_trigger === 1'b1) adc_cnt <= adc_cnt + 1;
	// Hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		chk(32'h0, 32'h1, "run timeout");
		final_report;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task final_report;
		if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One APB transfer; holds everything until pready is seen at an edge
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			chk(32'h0, 32'h1, "apb timeout");
			final_report;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One slow external clock period, well inside the synchroniser's reach
	task ext_pulse;
		ext_clk_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		ext_clk_pin <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task wait_flag;
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cflag !== 1'b1 && n < 300);
		if (cflag !== 1'b1) begin
			chk(32'h0, 32'h1, "flag timeout");
			final_report;
		end
	endtask
	// Compare run from count zero against value 12
	task run_cmp(input logic [3:0] mode, input logic at_m, input logic late, input logic clr);
		int a0;
		a0 = adc_cnt;
		apb(`CCPCU_OFS_COUNT, 1'b1, 32'h0);
		apb(`CCPCU_OFS_CTRL, 1'b1, {24'h0, 4'h8, mode});
		apb(`CCPCU_OFS_STATUS, 1'b1, 32'h1);
		wait_flag;
		chk({31'h0, pin}, {31'h0, at_m}, "pin at match");
		repeat (24) @(posedge pclk);
		chk({31'h0, pin}, {31'h0, late}, "pin later");
		chk({31'h0, wake_req}, 32'h1, "wake request");
		chk(adc_cnt - a0, 32'h1, "trigger pulses");
		apb(`CCPCU_OFS_COUNT, 1'b0, 32'h0);
		chk({31'h0, rd < 32'hC}, {31'h0, clr}, "timer clear");
	endtask
	// Setup order: duty and mode first, then period timer on 1:1 or prescaled tick
	task run_pwm(input logic [7:0] ctrl, input logic [31:0] duty, input logic [31:0] pctl,
		input logic [31:0] per, input logic [31:0] hi);
		logic [31:0] r0;
		int n;
		apb(`CCPCU_OFS_VALUE, 1'b1, duty);
		apb(`CCPCU_OFS_CTRL, 1'b1, {24'h0, ctrl});
		apb(`CCPCU_OFS_PCTL, 1'b1, pctl);
		r0 = rises;
		n = 0;
		while (rises - r0 < 32'h3 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		chk(rises - r0, 32'h3, "pwm edges");
		chk(last_period, per, "pwm period");
		chk(last_high, hi, "pwm high time");
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(`CCPCU_OFS_LIMIT, 1'b0, 32'h0);
		chk(rd, 32'hFF, "limit reset");
		apb(`CCPCU_OFS_CTRL, 1'b0, 32'h0);
		chk(rd, 32'h0, "control reset");
		apb(8'h40, 1'b1, 32'h1);
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(`CCPCU_OFS_VALUE, 1'b1, 32'hC);
		apb(`CCPCU_OFS_CFG, 1'b1, 32'h6);
		run_cmp(4'h8, 1'b1, 1'b1, 1'b0);
		run_cmp(4'h9, 1'b0, 1'b0, 1'b0);
		run_cmp(4'h2, 1'b1, 1'b1, 1'b0);
		// Pin stands high here, so the zero write really has to pull it down
		apb(`CCPCU_OFS_CTRL, 1'b1, 32'h0);
		@(posedge pclk);
		chk({31'h0, pin}, 32'h0, "zero control");
		run_cmp(4'h1, 1'b1, 1'b1, 1'b1);
		run_cmp(4'hA, 1'b1, 1'b0, 1'b0);
		run_cmp(4'hB, 1'b1, 1'b0, 1'b1);
		apb(`CCPCU_OFS_CTRL, 1'b1, 32'h0);
		apb(`CCPCU_OFS_STATUS, 1'b1, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, cflag}, 32'h0, "flag clear");
		chk({31'h0, wake_req}, 32'h0, "wake drop");
		// Sleep with instruction clocked timebase
		sleep_req <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(`CCPCU_OFS_COUNT, 1'b0, 32'h0);
		c0 = rd;
		repeat (40) @(posedge pclk);
		apb(`CCPCU_OFS_COUNT, 1'b0, 32'h0);
		chk(rd, c0, "count held");
		sleep_req <= 1'b0;
		repeat (40) @(posedge pclk);
		apb(`CCPCU_OFS_COUNT, 1'b0, 32'h0);
		chk({31'h0, rd > c0}, 32'h1, "count resumed");
		// Slow synchronised external clock keeps counting in sleep
		apb(`CCPCU_OFS_CFG, 1'b1, 32'h1);
		sleep_req <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(`CCPCU_OFS_COUNT, 1'b0, 32'h0);
		c0 = rd;
		repeat (10) ext_pulse;
		repeat (6) @(posedge pclk);
		apb(`CCPCU_OFS_COUNT, 1'b0, 32'h0);
		chk(rd, c0 + 32'hA, "external count");
		// Manual external edges leave room to rewrite the value before the clear
		apb(`CCPCU_OFS_COUNT, 1'b1, 32'hB);
		apb(`CCPCU_OFS_CTRL, 1'b1, 32'h8B);
		ext_pulse;
		wait_flag;
		apb(`CCPCU_OFS_VALUE, 1'b1, 32'h14);
		ext_pulse;
		apb(`CCPCU_OFS_COUNT, 1'b0, 32'h0);
		chk(rd, 32'hD, "clear cancelled");
		apb(`CCPCU_OFS_CTRL, 1'b1, 32'h0);
		sleep_req <= 1'b0;
		apb(`CCPCU_OFS_CFG, 1'b1, 32'h0);
		// PWM with period limit 9
		apb(`CCPCU_OFS_LIMIT, 1'b1, 32'h9);
		run_pwm(8'h8C, 32'h14, 32'h4, 32'h28, 32'h14);
		run_pwm(8'h9C, 32'h280, 32'h4, 32'h28, 32'hA);
		run_pwm(8'h8C, 32'h14, 32'h5, 32'hA0, 32'h50);
		chk({31'h0, pflag}, 32'h1, "period flag");
		apb(`CCPCU_OFS_VALUE, 1'b1, 32'h0);
		repeat (400) @(posedge pclk);
		c0 = rises;
		repeat (400) @(posedge pclk);
		chk(rises - c0, 32'h0, "zero duty edges");
		chk({31'h0, pin}, 32'h0, "zero duty pin");
		final_report;
	end
endmodule
